// File: src/bstl_defines.vh
// constants for the boundary-scan tap logic
// Operation
// - sixteen-state tap machine stepped by tck, tms
// - power-on or unused scan holds test-logic-reset
// - after configuration tap off unless design enables
// - config clear drops latched extest/load/dump decodes
// - three-bit instruction picks tdo and io source
// - 000 extest, 001 sample/preload from data register
// - 010/011 user instructions route user scan outs
// - 100 dump, 101 load disables io, 110 reserved
// - 111 bypass drives tdo from bypass stage
// - instruction bit 0 leaves tdo first
// - capture-ir loads status 1, 0, not-scan-config
// - shift-dr shifts all data registers always
// - three chain bits per io cell, none removed
// - data register captures on rising tck in capture-dr
// - update latch open in update-dr while tck low
// - latch drives io only under extest
// - extest captures every bit including internal outputs
// - global clocks come straight from pins
// - tap pins feed controller before boundary cells
// - tap pin output buffers disabled when scan selected
// - config clock, clear, complete pins not scanned
// - during configuration only sample and bypass work
// - bypass is one stage from tdi to tdo
// - user scan out passes falling-edge flop to tdo
// - user selects high while matching instruction held
// - gated dr clock follows tck in capture/shift-dr
`ifndef BSTL_DEFINES_VH
`define BSTL_DEFINES_VH

// ****************************************************************
// instruction codes
// ****************************************************************
`define BSTL_IR_W        3
`define BSTL_IR_EXTEST   3'h0
`define BSTL_IR_SAMPLE   3'h1
`define BSTL_IR_USER_A   3'h2
`define BSTL_IR_USER_B   3'h3
`define BSTL_IR_DUMP     3'h4
`define BSTL_IR_LOAD     3'h5
`define BSTL_IR_RSVD     3'h6
`define BSTL_IR_BYPASS   3'h7
`define BSTL_IR_RESET    3'h7
`define BSTL_IR_CAP_LOW  2'h1

// ****************************************************************
// chain layout
// ****************************************************************
`define BSTL_NUM_IO      8
`define BSTL_CELL_BITS   3
`define BSTL_CELL_OEN    0
`define BSTL_CELL_OUT    1
`define BSTL_CELL_IN     2
`define BSTL_NUM_TAP_IO  3

// ****************************************************************
// tap state bit indices (one-hot vector)
// ****************************************************************
`define BSTL_ST_W        16
`define BSTL_SI_TLR      0
`define BSTL_SI_RTI      1
`define BSTL_SI_SDS      2
`define BSTL_SI_CDR      3
`define BSTL_SI_SHD      4
`define BSTL_SI_E1D      5
`define BSTL_SI_PDR      6
`define BSTL_SI_E2D      7
`define BSTL_SI_UDR      8
`define BSTL_SI_SIS      9
`define BSTL_SI_CIR      10
`define BSTL_SI_SHI      11
`define BSTL_SI_E1I      12
`define BSTL_SI_PIR      13
`define BSTL_SI_E2I      14
`define BSTL_SI_UIR      15

`endif

// File: src/bstl_scan_chain.v
// boundary data register with update latches, three bits per io cell
`timescale 1ns/1ps
`include "bstl_defines.vh"
module bstl_scan_chain (
    // clock and reset
    input  wire                                        ref_clk,
    input  wire                                        nrst,
    // strobes and serial data in
    input  wire                                        capture,
    input  wire                                        shift,
    input  wire                                        update,
    input  wire                                        tdi,
    // parallel capture sources
    input  wire [`BSTL_NUM_IO-1:0]                     pinIn,
    input  wire [`BSTL_NUM_IO-1:0]                     coreOut,
    input  wire [`BSTL_NUM_IO-1:0]                     coreOeN,
    // results
    output wire                                        shiftOut,
    output reg  [`BSTL_NUM_IO*`BSTL_CELL_BITS-1:0]     latch_r
);
    localparam LEN = `BSTL_NUM_IO * `BSTL_CELL_BITS;

    reg  [LEN-1:0] shift_r;
    wire [LEN-1:0] capVec;

    // every cell keeps all three bits, used or not
    genvar i;
    generate
        for (i = 0; i < `BSTL_NUM_IO; i = i + 1) begin : gCell
            assign capVec[3*i+`BSTL_CELL_OEN] = coreOeN[i];
            assign capVec[3*i+`BSTL_CELL_OUT] = coreOut[i];
            assign capVec[3*i+`BSTL_CELL_IN]  = pinIn[i];
        end
    endgenerate

    assign shiftOut = shift_r[0];

    // capture, then shift toward tdo at bit 0
    always @(posedge ref_clk) begin
        if (!nrst) begin
            shift_r <= {LEN{1'b0}};
        end else if (capture) begin
            shift_r <= capVec;
        end else if (shift) begin
            shift_r <= {tdi, shift_r[LEN-1:1]};
        end
    end

    // latch follows the shifter while open, whatever the instruction
    always @(posedge ref_clk) begin
        if (!nrst) begin
            latch_r <= {LEN{1'b0}};
        end else if (update) begin
            latch_r <= shift_r;
        end
    end
endmodule // bstl_scan_chain

// File: src/bstl_tap_fsm.v
// sixteen-state tap controller stepped by sampled tck edges
`timescale 1ns/1ps
`include "bstl_defines.vh"
module bstl_tap_fsm (
    // clock and reset
    input  wire                   ref_clk,
    input  wire                   nrst,
    // control
    input  wire                   forceReset,
    input  wire                   tckRise,
    input  wire                   tms,
    // state
    output reg  [`BSTL_ST_W-1:0]  state_r
);
    localparam [15:0] S_TLR = 16'h0001;
    localparam [15:0] S_RTI = 16'h0002;
    localparam [15:0] S_SDS = 16'h0004;
    localparam [15:0] S_CDR = 16'h0008;
    localparam [15:0] S_SHD = 16'h0010;
    localparam [15:0] S_E1D = 16'h0020;
    localparam [15:0] S_PDR = 16'h0040;
    localparam [15:0] S_E2D = 16'h0080;
    localparam [15:0] S_UDR = 16'h0100;
    localparam [15:0] S_SIS = 16'h0200;
    localparam [15:0] S_CIR = 16'h0400;
    localparam [15:0] S_SHI = 16'h0800;
    localparam [15:0] S_E1I = 16'h1000;
    localparam [15:0] S_PIR = 16'h2000;
    localparam [15:0] S_E2I = 16'h4000;
    localparam [15:0] S_UIR = 16'h8000;

    reg [15:0] state_nxt;

    // standard transition graph, tms level at the rising tck edge
    always @* begin
        case (state_r)
            S_TLR:   state_nxt = tms ? S_TLR : S_RTI;
            S_RTI:   state_nxt = tms ? S_SDS : S_RTI;
            S_SDS:   state_nxt = tms ? S_SIS : S_CDR;
            S_CDR:   state_nxt = tms ? S_E1D : S_SHD;
            S_SHD:   state_nxt = tms ? S_E1D : S_SHD;
            S_E1D:   state_nxt = tms ? S_UDR : S_PDR;
            S_PDR:   state_nxt = tms ? S_E2D : S_PDR;
            S_E2D:   state_nxt = tms ? S_UDR : S_SHD;
            S_UDR:   state_nxt = tms ? S_SDS : S_RTI;
            S_SIS:   state_nxt = tms ? S_TLR : S_CIR;
            S_CIR:   state_nxt = tms ? S_E1I : S_SHI;
            S_SHI:   state_nxt = tms ? S_E1I : S_SHI;
            S_E1I:   state_nxt = tms ? S_UIR : S_PIR;
            S_PIR:   state_nxt = tms ? S_E2I : S_PIR;
            S_E2I:   state_nxt = tms ? S_UIR : S_SHI;
            S_UIR:   state_nxt = tms ? S_SDS : S_RTI;
            default: state_nxt = S_TLR;
        endcase
    end

    // forced reset wins over any tck edge
    always @(posedge ref_clk) begin
        if (!nrst || forceReset) begin
            state_r <= S_TLR;
        end else if (tckRise) begin
            state_r <= state_nxt;
        end
    end
endmodule // bstl_tap_fsm

// File: src/bstl_tap_logic.v
// top of the boundary-scan tap logic: sync, instruction, bypass, tdo, io muxing
`timescale 1ns/1ps
`include "bstl_defines.vh"
module bstl_tap_logic (
    // clock and reset
    input  wire                          ref_clk,
    input  wire                          nrst,
    // tap pins, taken before any boundary cell
    input  wire                          tckPin,
    input  wire                          tmsPin,
    input  wire                          tdiPin,
    output reg                           tdoOut_r,
    output reg                           tdoOeN_r,
    // configuration status
    input  wire                          cfgClearN,
    input  wire                          cfgDone,
    input  wire                          cfgBusy,
    input  wire                          cfgByScan,
    input  wire                          scanEnabled,
    // configuration datapaths
    input  wire                          readbackData,
    input  wire                          cfgSerialOut,
    output reg                           cfgLoadActive_r,
    output reg                           cfgDumpActive_r,
    // user register hookup
    input  wire                          userScanOutA,
    input  wire                          userScanOutB,
    output reg                           userSelectA_r,
    output reg                           userSelectB_r,
    output reg                           gatedDrClock_r,
    // io cells
    input  wire [`BSTL_NUM_IO-1:0]       padIn,
    input  wire [`BSTL_NUM_IO-1:0]       coreOut,
    input  wire [`BSTL_NUM_IO-1:0]       coreOeN,
    output reg  [`BSTL_NUM_IO-1:0]       padOut_r,
    output reg  [`BSTL_NUM_IO-1:0]       padOeN_r,
    output reg  [`BSTL_NUM_IO-1:0]       coreIn_r,
    // io cells that carry the tap inputs
    input  wire [`BSTL_NUM_TAP_IO-1:0]   tapIoOeN,
    output reg  [`BSTL_NUM_TAP_IO-1:0]   tapIoOeN_r,
    // global clocks
    input  wire [3:0]                    gclkPin,
    output reg  [3:0]                    gclkCore_r
);
    localparam CHAIN_LEN = `BSTL_NUM_IO * `BSTL_CELL_BITS;

    // ****************************************************************
    // functions
    // ****************************************************************

    // during configuration only sample and bypass stay usable
    function [2:0] gateInstr;
        input [2:0] ir;
        input       busy;
        begin
            if (busy && ir != `BSTL_IR_SAMPLE && ir != `BSTL_IR_BYPASS) begin
                gateInstr = `BSTL_IR_BYPASS;
            end else begin
                gateInstr = ir;
            end
        end
    endfunction

    // serial source for tdo while in shift-dr
    function tdoSource;
        input [2:0] ir;
        input       dr;
        input       byp;
        input       ua;
        input       ub;
        input       rb;
        input       cso;
        begin
            case (ir)
                `BSTL_IR_EXTEST: tdoSource = dr;
                `BSTL_IR_SAMPLE: tdoSource = dr;
                `BSTL_IR_USER_A: tdoSource = ua;
                `BSTL_IR_USER_B: tdoSource = ub;
                `BSTL_IR_DUMP:   tdoSource = rb;
                `BSTL_IR_LOAD:   tdoSource = cso;
                `BSTL_IR_BYPASS: tdoSource = byp;
                default:         tdoSource = byp;
            endcase
        end
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    reg                    tckS1_r;
    reg                    tckS2_r;
    reg                    tckS3_r;
    reg                    tmsS1_r;
    reg                    tmsS2_r;
    reg                    tdiS1_r;
    reg                    tdiS2_r;
    reg                    clrS1_r;
    reg                    clrS2_r;
    reg [`BSTL_NUM_IO-1:0] padS1_r;
    reg [`BSTL_NUM_IO-1:0] padS2_r;

    // two flops per pin, three on tck; the second stage feeds logic, the third only the tck edge detect
    always @(posedge ref_clk) begin
        if (!nrst) begin
            tckS1_r <= 1'b0;
            tckS2_r <= 1'b0;
            tckS3_r <= 1'b0;
            tmsS1_r <= 1'b1;
            tmsS2_r <= 1'b1;
            tdiS1_r <= 1'b1;
            tdiS2_r <= 1'b1;
            clrS1_r <= 1'b1;
            clrS2_r <= 1'b1;
            padS1_r <= {`BSTL_NUM_IO{1'b0}};
            padS2_r <= {`BSTL_NUM_IO{1'b0}};
        end else begin
            tckS1_r <= tckPin;
            tckS2_r <= tckS1_r;
            tckS3_r <= tckS2_r;
            tmsS1_r <= tmsPin;
            tmsS2_r <= tmsS1_r;
            tdiS1_r <= tdiPin;
            tdiS2_r <= tdiS1_r;
            clrS1_r <= cfgClearN;
            clrS2_r <= clrS1_r;
            padS1_r <= padIn;
            padS2_r <= padS1_r;
        end
    end

    wire tckRise = tckS2_r & ~tckS3_r;
    wire tckFall = ~tckS2_r & tckS3_r;

    // ****************************************************************
    // tap controller
    // ****************************************************************

    // unused after configuration means parked in reset
    wire tapEnable  = ~cfgDone | scanEnabled;
    wire forceReset = ~clrS2_r | ~tapEnable;

    wire [`BSTL_ST_W-1:0] state;

    bstl_tap_fsm uFsm (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .forceReset (forceReset),
        .tckRise    (tckRise),
        .tms        (tmsS2_r),
        .state_r    (state)
    );

    wire inTlr = state[`BSTL_SI_TLR];
    wire inCdr = state[`BSTL_SI_CDR];
    wire inShd = state[`BSTL_SI_SHD];
    wire inUdr = state[`BSTL_SI_UDR];
    wire inCir = state[`BSTL_SI_CIR];
    wire inShi = state[`BSTL_SI_SHI];
    wire inUir = state[`BSTL_SI_UIR];

    // ****************************************************************
    // instruction register
    // ****************************************************************
    reg [`BSTL_IR_W-1:0] irShift_r;
    reg [`BSTL_IR_W-1:0] irActive_r;
    reg                  extestLat_r;

    // status capture, then shift with bit 0 nearest tdo
    always @(posedge ref_clk) begin
        if (!nrst) begin
            irShift_r <= `BSTL_IR_RESET;
        end else if (tckRise && inCir) begin
            irShift_r <= {~cfgByScan, `BSTL_IR_CAP_LOW};
        end else if (tckRise && inShi) begin
            irShift_r <= {tdiS2_r, irShift_r[2:1]};
        end
    end

    // new instruction takes effect on the falling edge in update-ir
    always @(posedge ref_clk) begin
        if (!nrst || inTlr) begin
            irActive_r <= `BSTL_IR_RESET;
        end else if (tckFall && inUir) begin
            irActive_r <= irShift_r;
        end
    end

    wire [2:0] irEff = gateInstr(irActive_r, cfgBusy);

    // latched decodes; config clear drops them at once
    always @(posedge ref_clk) begin
        if (!nrst || !clrS2_r) begin
            extestLat_r     <= 1'b0;
            cfgLoadActive_r <= 1'b0;
            cfgDumpActive_r <= 1'b0;
        end else begin
            extestLat_r     <= (irEff == `BSTL_IR_EXTEST);
            cfgLoadActive_r <= (irEff == `BSTL_IR_LOAD);
            cfgDumpActive_r <= (irEff == `BSTL_IR_DUMP);
        end
    end

    // ****************************************************************
    // data registers
    // ****************************************************************
    reg                  bypass_r;
    wire                 drOut;
    wire [CHAIN_LEN-1:0] latch;

    // single bypass stage, shifting in every shift-dr
    always @(posedge ref_clk) begin
        if (!nrst) begin
            bypass_r <= 1'b0;
        end else if (tckRise && inCdr) begin
            bypass_r <= 1'b0;
        end else if (tckRise && inShd) begin
            bypass_r <= tdiS2_r;
        end
    end

    // chain holds io cells only; config pins have no cells
    bstl_scan_chain uChain (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .capture  (tckRise & inCdr),
        .shift    (tckRise & inShd),
        .update   (inUdr & ~tckS2_r),
        .tdi      (tdiS2_r),
        .pinIn    (padS2_r),
        .coreOut  (coreOut),
        .coreOeN  (coreOeN),
        .shiftOut (drOut),
        .latch_r  (latch)
    );

    // ****************************************************************
    // tdo output stage
    // ****************************************************************

    // falling-edge stage also serves as the user scan delay flop
    always @(posedge ref_clk) begin
        if (!nrst) begin
            tdoOut_r <= 1'b0;
            tdoOeN_r <= 1'b1;
        end else if (tckFall) begin
            tdoOeN_r <= ~(inShi | inShd);
            if (inShi) begin
                tdoOut_r <= irShift_r[0];
            end else begin
                tdoOut_r <= tdoSource(irEff, drOut, bypass_r, userScanOutA,
                                      userScanOutB, readbackData,
                                      cfgSerialOut);
            end
        end else if (inTlr) begin
            tdoOeN_r <= 1'b1;
        end
    end

    // ****************************************************************
    // user register hookup
    // ****************************************************************

    // gated clock is a delayed copy of tck, low outside dr capture/shift
    always @(posedge ref_clk) begin
        if (!nrst) begin
            userSelectA_r  <= 1'b0;
            userSelectB_r  <= 1'b0;
            gatedDrClock_r <= 1'b0;
        end else begin
            userSelectA_r  <= (irEff == `BSTL_IR_USER_A);
            userSelectB_r  <= (irEff == `BSTL_IR_USER_B);
            gatedDrClock_r <= tckS2_r & (inCdr | inShd);
        end
    end

    // ****************************************************************
    // io cell muxing
    // ****************************************************************
    wire [`BSTL_NUM_IO-1:0] latOeN;
    wire [`BSTL_NUM_IO-1:0] latOut;
    wire [`BSTL_NUM_IO-1:0] latIn;

    genvar g;
    generate
        for (g = 0; g < `BSTL_NUM_IO; g = g + 1) begin : gLat
            assign latOeN[g] = latch[3*g+`BSTL_CELL_OEN];
            assign latOut[g] = latch[3*g+`BSTL_CELL_OUT];
            assign latIn[g]  = latch[3*g+`BSTL_CELL_IN];
        end
    endgenerate

    // latch data reaches pins and core only under extest
    always @(posedge ref_clk) begin
        if (!nrst) begin
            padOut_r <= {`BSTL_NUM_IO{1'b0}};
            padOeN_r <= {`BSTL_NUM_IO{1'b1}};
            coreIn_r <= {`BSTL_NUM_IO{1'b0}};
        end else begin
            padOut_r <= extestLat_r ? latOut : coreOut;
            coreIn_r <= extestLat_r ? latIn : padS2_r;
            if (cfgLoadActive_r) begin
                padOeN_r <= {`BSTL_NUM_IO{1'b1}};
            end else begin
                padOeN_r <= extestLat_r ? latOeN : coreOeN;
            end
        end
    end

    // tap input pads never drive while scan is selected; clocks never muxed
    always @(posedge ref_clk) begin
        if (!nrst) begin
            tapIoOeN_r <= {`BSTL_NUM_TAP_IO{1'b1}};
            gclkCore_r <= 4'h0;
        end else begin
            tapIoOeN_r <= tapEnable ? {`BSTL_NUM_TAP_IO{1'b1}} : tapIoOeN;
            gclkCore_r <= gclkPin;
        end
    end
endmodule // bstl_tap_logic

// File: tb/bstl_tap_logic_sva.sv
// port-level assertions for the boundary-scan tap logic
`timescale 1ns/1ps
module bstl_tap_sva (
    // clock and reset
    input logic       ref_clk,
    input logic       nrst,
    // tap and configuration
    input logic       tckPin,
    input logic       tdoOut_r,
    input logic       tdoOeN_r,
    input logic       cfgClearN,
    input logic       cfgDone,
    input logic       cfgBusy,
    input logic       scanEnabled,
    // decodes, user hookup, tap pad enables and global clocks
    input logic       cfgLoadActive_r,
    input logic       cfgDumpActive_r,
    input logic       userSelectA_r,
    input logic       userSelectB_r,
    input logic       gatedDrClock_r,
    input logic [2:0] tapIoOeN_r,
    input logic [3:0] gclkPin,
    input logic [3:0] gclkCore_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ****
    // hold sequences spanning the pin synchronisers
    // ****
    sequence sClear; !cfgClearN [*6]; endsequence
    sequence sTapOff; (cfgDone && !scanEnabled) [*6]; endsequence
    chk_clear_decodes: assert property (sClear |-> !cfgLoadActive_r && !cfgDumpActive_r)
        else $error("decode kept through config clear");
    chk_clear_tap: assert property (sClear |-> tdoOeN_r && !userSelectA_r && !userSelectB_r)
        else $error("tap not reset by config clear");
    chk_off_after_cfg: assert property (sTapOff |-> tdoOeN_r && !userSelectA_r && !userSelectB_r)
        else $error("tap active without scan enable");
    chk_busy_user_off: assert property (cfgBusy [*3] |-> !userSelectA_r && !userSelectB_r)
        else $error("user select while configuring");
    chk_decode_onehot: assert property ($onehot0({userSelectA_r, userSelectB_r, cfgLoadActive_r, cfgDumpActive_r}))
        else $error("two decodes active");
    chk_gclk_direct: assert property ($past(nrst) |-> gclkCore_r == $past(gclkPin))
        else $error("global clock not from pin");
    chk_tapio_off: assert property ((scanEnabled || !cfgDone) [*2] |-> tapIoOeN_r == 3'h7)
        else $error("tap pad driver enabled");
    chk_tdo_on_fall: assert property ($changed(tdoOut_r) |-> !$past(tckPin, 2))
        else $error("tdo moved outside tck low");
    chk_drclk_gated: assert property (gatedDrClock_r |-> $past(tckPin, 3) || $past(tckPin, 4))
        else $error("dr clock high while tck low");
endmodule // bstl_tap_sva
bind bstl_tap_logic bstl_tap_sva u_bstl_tap_sva (.ref_clk, .nrst, .tckPin, .tdoOut_r,
    .tdoOeN_r, .cfgClearN, .cfgDone, .cfgBusy, .scanEnabled, .cfgLoadActive_r,
    .cfgDumpActive_r, .userSelectA_r, .userSelectB_r, .gatedDrClock_r, .tapIoOeN_r,
    .gclkPin, .gclkCore_r);

// File: tb/bstl_tap_tester.sv
// external test controller model driving the tap pins
`timescale 1ns/1ps
module bstl_tap_tester (
    // clock
    input  logic refClk,
    // tap lines
    output logic tck,
    output logic tms,
    output logic tdi,
    input  logic tdoOut,
    input  logic tdoOeN
);
    // released tdo floats to its pull-up, never to the last bit
    wire tdoLine = tdoOeN ? 1'b1 : tdoOut;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // ****
    // one 400 ns tck period; tdo read late in the high phase
    // ****
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge refClk);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (4) @(negedge refClk);
        tck = 1'b1;
        repeat (3) @(negedge refClk);
        q = tdoLine;
    endtask
    // tms path taken lsb first
    task automatic walk(input int n, input logic [7:0] path);
        logic q;
        for (int i = 0; i < n; i++) begin
            step(path[i], 1'b1, q);
        end
    endtask
    // shift lsb first, leave on the last bit, then update and idle
    task automatic shift(input int n, input logic [23:0] din, output logic [23:0] dout);
        dout = 24'h00_0000;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        walk(2, 8'h01);
    endtask
    task automatic ir(input logic [2:0] code, output logic [2:0] cap);
        logic [23:0] q;
        walk(4, 8'h03);
        shift(3, 24'(code), q);
        cap = q[2:0];
    endtask
    task automatic dr(input logic [23:0] din, output logic [23:0] dout);
        walk(3, 8'h01);
        shift(24, din, dout);
    endtask
endmodule // bstl_tap_tester

// File: tb/tb_bstl_tap_logic.sv
// self-checking bench for the boundary-scan tap logic
`timescale 1ns/1ps
module tb_bstl_tap_logic;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic cfgClearN = 1'b1, cfgDone = 1'b0, cfgBusy = 1'b0, cfgByScan = 1'b0;
    logic scanEnabled = 1'b1, readbackData = 1'b0, cfgSerialOut = 1'b0;
    logic userScanOutA = 1'b0, userScanOutB = 1'b0;
    logic [7:0] padIn = 8'h00, coreOut = 8'h00, coreOeN = 8'hff;
    logic [2:0] tapIoOeN = 3'h7;
    logic [3:0] gclkPin = 4'h0;
    wire tckPin, tmsPin, tdiPin, tdoOut_r, tdoOeN_r, cfgLoadActive_r, cfgDumpActive_r;
    wire userSelectA_r, userSelectB_r, gatedDrClock_r;
    wire [7:0] padOut_r, padOeN_r, coreIn_r;
    wire [2:0] tapIoOeN_r;
    wire [3:0] gclkCore_r;
    int fails = 0;
    int samplesChecked = 0;
    always #25 ref_clk = ~ref_clk;
    // free-running pins keep the pass-through paths busy
    always @(negedge ref_clk) begin
        gclkPin <= 4'($urandom);
        tapIoOeN <= 3'($urandom);
    end
    bstl_tap_logic u_bstl_tap_logic (.ref_clk, .nrst, .tckPin, .tmsPin, .tdiPin, .tdoOut_r,
        .tdoOeN_r, .cfgClearN, .cfgDone, .cfgBusy, .cfgByScan, .scanEnabled, .readbackData,
        .cfgSerialOut, .cfgLoadActive_r, .cfgDumpActive_r, .userScanOutA, .userScanOutB,
        .userSelectA_r, .userSelectB_r, .gatedDrClock_r, .padIn, .coreOut, .coreOeN,
        .padOut_r, .padOeN_r, .coreIn_r, .tapIoOeN, .tapIoOeN_r, .gclkPin, .gclkCore_r);
    bstl_tap_tester u_bstl_tap_tester (.refClk(ref_clk), .tck(tckPin), .tms(tmsPin),
        .tdi(tdiPin), .tdoOut(tdoOut_r), .tdoOeN(tdoOeN_r));
    // ****
    // expectations and comparisons
    // ****
    function automatic logic [23:0] chainOf(logic [7:0] oe, logic [7:0] o, logic [7:0] i);
        for (int k = 0; k < 8; k++) begin
            chainOf[3*k] = oe[k];
            chainOf[3*k+1] = o[k];
            chainOf[3*k+2] = i[k];
        end
    endfunction
    function automatic logic [7:0] fieldOf(logic [23:0] w, int pos);
        for (int k = 0; k < 8; k++) begin
            fieldOf[k] = w[3*k+pos];
        end
    endfunction
    // bypass puts its captured zero out first
    function automatic logic [23:0] tdoExp(logic [2:0] c, logic [23:0] cap, logic [23:0] din);
        case (c)
            3'h0, 3'h1: tdoExp = cap;
            3'h2: tdoExp = {24{userScanOutA}};
            3'h3: tdoExp = {24{userScanOutB}};
            3'h4: tdoExp = {24{readbackData}};
            3'h5: tdoExp = {24{cfgSerialOut}};
            default: tdoExp = {din[22:0], 1'b0};
        endcase
    endfunction
    task automatic cmpWord(input logic [23:0] got, input logic [23:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmpFlag(input logic got, input logic exp);
        cmpWord(24'(got), 24'(exp));
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watchdog well beyond the expected 141 us of traffic
    initial begin
        #1000000;
        fails++;
        summarize();
    end
    initial begin
        logic [2:0] cap;
        logic [23:0] din, dout, want;
        void'($urandom(18));
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (4) @(negedge ref_clk);
        u_bstl_tap_tester.walk(6, 8'h1f);
        // configuring by scan: user instruction refused
        cfgBusy = 1'b1;
        cfgByScan = 1'b1;
        u_bstl_tap_tester.ir(3'h2, cap);
        cmpWord(24'(cap), 24'h00_0001);
        cmpFlag(userSelectA_r, 1'b0);
        cfgBusy = 1'b0;
        cfgByScan = 1'b0;
        cfgDone = 1'b1;
        // every code with fresh random pins and scan data
        for (int c = 0; c < 8; c++) begin
            {padIn, coreOut, coreOeN} = 24'($urandom);
            {userScanOutA, userScanOutB, readbackData, cfgSerialOut} = 4'($urandom);
            din = 24'($urandom);
            u_bstl_tap_tester.ir(3'(c), cap);
            cmpWord(24'(cap), 24'h00_0005);
            cmpFlag(userSelectA_r, c == 2);
            cmpFlag(userSelectB_r, c == 3);
            cmpFlag(cfgDumpActive_r, c == 4);
            cmpFlag(cfgLoadActive_r, c == 5);
            want = tdoExp(3'(c), chainOf(coreOeN, coreOut, padIn), din);
            u_bstl_tap_tester.dr(din, dout);
            cmpWord(dout, want);
            if (c == 0) begin
                cmpWord(24'(padOut_r), 24'(fieldOf(din, 1)));
                cmpWord(24'(padOeN_r), 24'(fieldOf(din, 0)));
                cmpWord(24'(coreIn_r), 24'(fieldOf(din, 2)));
            end else if (c != 5) begin
                cmpWord(24'(padOut_r), 24'(coreOut));
            end
        end
        // latch took the data shifted under bypass
        u_bstl_tap_tester.ir(3'h0, cap);
        cmpWord(24'(padOut_r), 24'(fieldOf(din, 1)));
        scanEnabled = 1'b0;
        u_bstl_tap_tester.ir(3'h3, cap);
        cmpFlag(userSelectB_r, 1'b0);
        scanEnabled = 1'b1;
        u_bstl_tap_tester.walk(6, 8'h1f);
        u_bstl_tap_tester.ir(3'h4, cap);
        cmpFlag(cfgDumpActive_r, 1'b1);
        cfgClearN = 1'b0;
        repeat (3) @(negedge ref_clk);
        cmpFlag(cfgDumpActive_r, 1'b0);
        cfgClearN = 1'b1;
        summarize();
    end
endmodule // tb_bstl_tap_logic
